// File: flash_host_model.sv
`timescale 1ns/1ps
module flash_host_model (
  // Clock.
  input wire logic clk_in,
  // Serial pins towards the device.
  output logic sel_n_out,
  output logic sclk_out,
  output logic [3:0] line_out
);
  initial begin
    sel_n_out = 1'b1;
    sclk_out = 1'b0;
    line_out = 4'h0;
  end
  ////////////////////////////////////////
  // Keeps a gap with select high, then selects; the clock stays low outside frames.
  task automatic start();
    repeat (6) @(negedge clk_in);
    sel_n_out = 1'b0;
    repeat (4) @(negedge clk_in);
  endtask
  // Shifts g groups of w bits, most significant first; g of 0 means a whole byte.
  task automatic send(input logic [7:0] b, input int w, input int g);
    logic [7:0] s;
    int n;
    s = b;
    n = (g == 0) ? 8 / w : g;
    for (int k = 0; k < n; k++) begin
      line_out = 4'(s >> (8 - w));
      s = s << w;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b1;
      repeat (4) @(negedge clk_in);
      sclk_out = 1'b0;
    end
  endtask
  // Deselects after the last unit; released lines show a changed level.
  task automatic stop();
    repeat (4) @(negedge clk_in);
    sel_n_out = 1'b1;
    line_out = ~line_out;
  endtask
endmodule

// File: flash_seq_checker.sv
`timescale 1ns/1ps
module flash_seq_checker #(
  parameter int PAGE_SIZE = 256
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Array side.
  input wire logic mem_we_out,
  input wire logic [31:0] mem_addr_out,
  input wire logic erase_start_out,
  input wire logic erase_sector_out,
  input wire logic [31:0] erase_addr_out,
  // Status.
  input wire logic wel_out,
  input wire logic [7:0] fsr_out
);
  localparam int PW = $clog2(PAGE_SIZE);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  ////////////////////////////////////////
  a_reset_status: assert property ($fell(srst_in) |-> fsr_out == 8'h80 && !wel_out)
    else $error("status not at reset value");
  a_busy_no_latch: assert property (!fsr_out[7] |-> !wel_out)
    else $error("latch set while busy");
  a_prot_keeps_latch: assert property ($rose(fsr_out[1]) |-> wel_out && (fsr_out[4] || fsr_out[5]))
    else $error("protection error without latch or fail bit");
  a_prog_fail_latch: assert property ($rose(fsr_out[4]) && !fsr_out[1] |-> !wel_out && fsr_out[7])
    else $error("program fail with latch set or busy");
  a_erase_fail_latch: assert property ($rose(fsr_out[5]) && !fsr_out[1] |-> !wel_out && fsr_out[7])
    else $error("erase fail with latch set or busy");
  a_erase_aligned: assert property (erase_start_out |-> erase_addr_out[11:0] == 12'h000 &&
    !(erase_sector_out && erase_addr_out[15:12] != 4'h0))
    else $error("erase address not aligned");
  a_erase_needs_latch: assert property (erase_start_out |-> $past(wel_out) && !fsr_out[7])
    else $error("erase started without latch");
  a_write_same_page: assert property (mem_we_out && $past(mem_we_out) |->
    mem_addr_out[31:PW] == $past(mem_addr_out[31:PW]) && mem_addr_out > $past(mem_addr_out))
    else $error("page write left its page");
  a_write_while_busy: assert property (mem_we_out |-> !fsr_out[7])
    else $error("array write while ready");
  a_suspend_ready: assert property ($rose(fsr_out[6]) |-> fsr_out[7] && !wel_out)
    else $error("erase suspend without ready");
  c_page_write: cover property (mem_we_out);
  c_suspend: cover property ($rose(fsr_out[6]));
  c_sector_erase: cover property (erase_start_out && erase_sector_out);
  c_protect: cover property ($rose(fsr_out[1]));
endmodule
bind serial_flash_program_erase_control flash_seq_checker #(.PAGE_SIZE(PAGE_SIZE)) chk_i (
  .clk_in(clk_in), .srst_in(srst_in), .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
  .erase_start_out(erase_start_out), .erase_sector_out(erase_sector_out),
  .erase_addr_out(erase_addr_out), .wel_out(wel_out), .fsr_out(fsr_out));

// File: flash_seq_consts.svh
`ifndef FLASH_SEQ_CONSTS_SVH
`define FLASH_SEQ_CONSTS_SVH
`define CMD_WRITE_ENABLE 8'h06
`define CMD_WRITE_DISABLE 8'h04
`define CMD_PAGE_PROGRAM 8'h02
`define CMD_DUAL_PROGRAM 8'ha2
`define CMD_EXT_DUAL_PROGRAM 8'hd2
`define CMD_QUAD_PROGRAM 8'h32
`define CMD_EXT_QUAD_PROGRAM 8'h38
`define CMD_SUBSECTOR_ERASE 8'h20
`define CMD_SECTOR_ERASE 8'hd8
`define FSR_RESET 8'h80
`define FSR_READY_BIT 7
`define FSR_ERASE_SUSP_BIT 6
`define FSR_ERASE_FAIL_BIT 5
`define FSR_PROG_FAIL_BIT 4
`define FSR_PROG_SUSP_BIT 2
`define FSR_PROT_BIT 1
`define CLK_MHZ 50
`define PAGE_PROGRAM_TIME_US 500
`define SUBSECTOR_ERASE_TIME_US 250000
`define SECTOR_ERASE_TIME_US 700000
`define TIMEOUT_FACTOR 4
`endif

// File: flash_seq_pkg.sv
package flash_seq_pkg;
  typedef enum logic [1:0] {PROTO_EXT = 2'b00, PROTO_DUAL = 2'b01, PROTO_QUAD = 2'b10} proto_t;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_CMD = 3'b001, PH_ADDR = 3'b011, PH_DATA = 3'b010, PH_EXTRA = 3'b110
  } phase_t;
  typedef enum logic [1:0] {EX_IDLE = 2'b00, EX_FLUSH = 2'b01, EX_TIME = 2'b11, EX_SUSP = 2'b10} exec_t;
endpackage

// File: serial_flash_program_erase_control.sv
`timescale 1ns/1ps
`include "flash_seq_consts.svh"
module serial_flash_program_erase_control import flash_seq_pkg::*; #(
  parameter int PAGE_SIZE = 256,
  parameter int SUBSECTOR_W = 12,
  parameter int SECTOR_W = 16,
  parameter int unsigned PP_CYCLES = `PAGE_PROGRAM_TIME_US * `CLK_MHZ,
  parameter int unsigned SSE_CYCLES = `SUBSECTOR_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned SE_CYCLES = `SECTOR_ERASE_TIME_US * `CLK_MHZ,
  parameter int unsigned PP_LIMIT = PP_CYCLES * `TIMEOUT_FACTOR,
  parameter int unsigned SSE_LIMIT = SSE_CYCLES * `TIMEOUT_FACTOR,
  parameter int unsigned SE_LIMIT = SE_CYCLES * `TIMEOUT_FACTOR
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic srst_in,
  // Serial pins from the host.
  input wire logic sel_n_in,
  input wire logic sclk_in,
  input wire logic [3:0] serial_line_in,
  // Device configuration.
  input wire logic [1:0] proto_in,
  input wire logic addr4_in,
  input wire logic clr_fsr_in,
  input wire logic suspend_in,
  input wire logic resume_in,
  // Protection lookup.
  output logic [31:0] prot_addr_out,
  input wire logic prot_hit_in,
  // Array side.
  input wire logic array_ready_in,
  output logic mem_we_out,
  output logic [31:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic erase_start_out,
  output logic erase_sector_out,
  output logic [31:0] erase_addr_out,
  // Status.
  output logic wel_out,
  output logic [7:0] fsr_out
);

  localparam int PAGE_W = $clog2(PAGE_SIZE);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  logic sel_s1_reg, sel_s2_reg, sel_s3_reg;
  logic sclk_s1_reg, sclk_s2_reg, sclk_s3_reg;
  logic [3:0] dq_s1_reg, dq_s2_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      {sel_s3_reg, sel_s2_reg, sel_s1_reg} <= 3'h7;
      {sclk_s3_reg, sclk_s2_reg, sclk_s1_reg} <= 3'h0;
      {dq_s2_reg, dq_s1_reg} <= 8'h00;
    end else begin
      {sel_s3_reg, sel_s2_reg, sel_s1_reg} <= {sel_s2_reg, sel_s1_reg, sel_n_in};
      {sclk_s3_reg, sclk_s2_reg, sclk_s1_reg} <= {sclk_s2_reg, sclk_s1_reg, sclk_in};
      {dq_s2_reg, dq_s1_reg} <= {dq_s1_reg, serial_line_in};
    end
  end

  logic frame_start, frame_end, sclk_rise;
  assign frame_start = ~sel_s2_reg & sel_s3_reg;
  assign frame_end = sel_s2_reg & ~sel_s3_reg;
  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg & ~sel_s2_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode.
  phase_t phase_reg;
  exec_t state_reg, state_next;
  logic [7:0] cmd_reg;
  logic [5:0] bit_cnt_reg;
  logic [31:0] shift_reg, addr_reg;
  logic have_data_reg;
  logic [PAGE_W-1:0] wptr_reg;
  logic op_prog, op_erase, supported;
  logic [2:0] proto_w, addr_w, data_w, cur_w;
  logic [5:0] addr_bits;

  assign proto_w = (proto_in == PROTO_QUAD) ? 3'd4 : (proto_in == PROTO_DUAL) ? 3'd2 : 3'd1;

  always_comb begin
    op_prog = 1'b0;
    op_erase = 1'b0;
    supported = 1'b1;
    addr_w = proto_w;
    data_w = proto_w;
    case (cmd_reg)
      `CMD_PAGE_PROGRAM: op_prog = 1'b1;
      `CMD_DUAL_PROGRAM, `CMD_EXT_DUAL_PROGRAM: begin
        op_prog = 1'b1;
        supported = (proto_in != PROTO_QUAD);
        if (proto_in == PROTO_EXT) begin
          data_w = 3'd2;
          addr_w = (cmd_reg == `CMD_EXT_DUAL_PROGRAM) ? 3'd2 : 3'd1;
        end
      end
      `CMD_QUAD_PROGRAM, `CMD_EXT_QUAD_PROGRAM: begin
        op_prog = 1'b1;
        supported = (proto_in != PROTO_DUAL);
        if (proto_in == PROTO_EXT) begin
          data_w = 3'd4;
          addr_w = (cmd_reg == `CMD_EXT_QUAD_PROGRAM) ? 3'd4 : 3'd1;
        end
      end
      `CMD_SUBSECTOR_ERASE, `CMD_SECTOR_ERASE: op_erase = 1'b1;
      default: supported = 1'b0;
    endcase
  end

  assign addr_bits = addr4_in ? 6'd32 : 6'd24;

  assign cur_w = (phase_reg == PH_ADDR) ? addr_w : (phase_reg == PH_DATA) ? data_w : proto_w;

  logic [31:0] shift_next;
  logic [5:0] cnt_next;
  always_comb begin
    case (cur_w)
      3'd2: shift_next = {shift_reg[29:0], dq_s2_reg[1:0]};
      3'd4: shift_next = {shift_reg[27:0], dq_s2_reg[3:0]};
      default: shift_next = {shift_reg[30:0], dq_s2_reg[0]};
    endcase
    cnt_next = bit_cnt_reg + {3'd0, cur_w};
  end

  logic byte_done;
  assign byte_done = sclk_rise && phase_reg == PH_DATA && op_prog && cnt_next == 6'd8;

  ////////////////////////////////////////////////////////////////////////////////
  // Frame receiver.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      phase_reg <= PH_IDLE;
      bit_cnt_reg <= 6'd0;
      shift_reg <= 32'h0;
      cmd_reg <= 8'h00;
      addr_reg <= 32'h0;
      have_data_reg <= 1'b0;
      wptr_reg <= '0;
    end else if (frame_start) begin
      phase_reg <= (state_reg == EX_IDLE) ? PH_CMD : PH_EXTRA;
      bit_cnt_reg <= 6'd0;
      have_data_reg <= 1'b0;
    end else if (sclk_rise) begin
      shift_reg <= shift_next;
      bit_cnt_reg <= cnt_next;
      case (phase_reg)
        PH_CMD: begin
          if (cnt_next == 6'd8) begin
            cmd_reg <= shift_next[7:0];
            phase_reg <= PH_ADDR;
            bit_cnt_reg <= 6'd0;
          end
        end
        PH_ADDR: begin
          if (!(op_prog || op_erase) || !supported) begin
            phase_reg <= PH_EXTRA;
          end else if (cnt_next == addr_bits) begin
            addr_reg <= addr4_in ? shift_next : {8'h00, shift_next[23:0]};
            wptr_reg <= shift_next[PAGE_W-1:0];
            phase_reg <= PH_DATA;
            bit_cnt_reg <= 6'd0;
          end
        end
        PH_DATA: begin
          if (op_erase) begin
            phase_reg <= PH_EXTRA;
          end else if (cnt_next == 6'd8) begin
            wptr_reg <= wptr_reg + 1'b1;
            have_data_reg <= 1'b1;
            bit_cnt_reg <= 6'd0;
          end
        end
        default: bit_cnt_reg <= bit_cnt_reg;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Page buffer: later bytes overwrite earlier ones at the same column.

  logic [7:0] page_data_reg [PAGE_SIZE];
  logic [PAGE_SIZE-1:0] page_valid_reg;

  genvar gi;
  generate
    for (gi = 0; gi < PAGE_SIZE; gi++) begin : g_page
      always_ff @(posedge clk_in) begin
        if (srst_in) begin
          page_valid_reg[gi] <= 1'b0;
          page_data_reg[gi] <= 8'hff;
        end else if (frame_start && state_reg == EX_IDLE) begin
          page_valid_reg[gi] <= 1'b0;
        end else if (byte_done && wptr_reg == PAGE_W'(gi)) begin
          page_data_reg[gi] <= shift_next[7:0];
          page_valid_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Frame end decisions.
  logic end_wren, end_wrdi, end_op, go, prot_err;
  assign end_wren = frame_end && phase_reg == PH_ADDR && bit_cnt_reg == 6'd0
                    && cmd_reg == `CMD_WRITE_ENABLE;
  assign end_wrdi = frame_end && phase_reg == PH_ADDR && bit_cnt_reg == 6'd0
                    && cmd_reg == `CMD_WRITE_DISABLE;
  assign end_op = frame_end && phase_reg == PH_DATA && bit_cnt_reg == 6'd0 && supported
                  && ((op_prog && have_data_reg) || op_erase);
  assign go = end_op && wel_out && !prot_hit_in;
  assign prot_err = end_op && wel_out && prot_hit_in;
  assign prot_addr_out = addr_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Operation sequencer.
  logic [31:0] timer_reg, dur, lim;
  logic [PAGE_W-1:0] flush_idx_reg;
  logic is_erase_reg, is_sector_reg;
  logic timeout, done;

  always_comb begin
    if (!is_erase_reg) begin
      dur = PP_CYCLES;
      lim = PP_LIMIT;
    end else if (is_sector_reg) begin
      dur = SE_CYCLES;
      lim = SE_LIMIT;
    end else begin
      dur = SSE_CYCLES;
      lim = SSE_LIMIT;
    end
  end

  assign timeout = state_reg == EX_TIME && timer_reg >= lim;
  assign done = state_reg == EX_TIME && timer_reg >= dur && array_ready_in;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EX_IDLE: if (go) state_next = op_erase ? EX_TIME : EX_FLUSH;
      EX_FLUSH: if (flush_idx_reg == PAGE_W'(PAGE_SIZE - 1)) state_next = EX_TIME;
      EX_TIME: begin
        if (timeout || done) begin
          state_next = EX_IDLE;
        end else if (suspend_in) begin
          state_next = EX_SUSP;
        end
      end
      EX_SUSP: if (resume_in) state_next = EX_TIME;
      default: state_next = EX_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state_reg <= EX_IDLE;
      timer_reg <= 32'h0;
      flush_idx_reg <= '0;
      is_erase_reg <= 1'b0;
      is_sector_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == EX_IDLE) begin
        timer_reg <= 32'h0;
        flush_idx_reg <= '0;
        if (go) begin
          is_erase_reg <= op_erase;
          is_sector_reg <= (cmd_reg == `CMD_SECTOR_ERASE);
        end
      end else if (state_reg != EX_SUSP) begin
        timer_reg <= timer_reg + 32'd1;
        flush_idx_reg <= flush_idx_reg + 1'b1;
      end
    end
  end

  // The page is copied out one column a cycle; unwritten columns are skipped.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      mem_we_out <= 1'b0;
      mem_addr_out <= 32'h0;
      mem_data_out <= 8'hff;
      erase_start_out <= 1'b0;
      erase_sector_out <= 1'b0;
      erase_addr_out <= 32'h0;
    end else begin
      mem_we_out <= state_reg == EX_FLUSH && page_valid_reg[flush_idx_reg];
      mem_addr_out <= {addr_reg[31:PAGE_W], flush_idx_reg};
      mem_data_out <= page_data_reg[flush_idx_reg];
      erase_start_out <= go && op_erase;
      if (go && op_erase) begin
        erase_sector_out <= (cmd_reg == `CMD_SECTOR_ERASE);
        if (cmd_reg == `CMD_SECTOR_ERASE) begin
          erase_addr_out <= {addr_reg[31:SECTOR_W], {SECTOR_W{1'b0}}};
        end else begin
          erase_addr_out <= {addr_reg[31:SUBSECTOR_W], {SUBSECTOR_W{1'b0}}};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write enable latch and flag status.

  logic wel_reg;
  logic ready_reg, susp_p_reg, susp_e_reg, fail_p_reg, fail_e_reg, prot_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      wel_reg <= 1'b0;
    end else if (go || timeout) begin
      wel_reg <= 1'b0;
    end else if (end_wren) begin
      wel_reg <= 1'b1;
    end else if (clr_fsr_in) begin
      wel_reg <= 1'b0;
    end else if (end_wrdi && !prot_reg) begin
      wel_reg <= 1'b0;
    end
  end
  assign wel_out = wel_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ready_reg <= 1'(`FSR_RESET >> `FSR_READY_BIT);
      susp_p_reg <= 1'b0;
      susp_e_reg <= 1'b0;
    end else begin
      ready_reg <= state_next == EX_IDLE || state_next == EX_SUSP;
      susp_p_reg <= state_next == EX_SUSP && !is_erase_reg;
      susp_e_reg <= state_next == EX_SUSP && is_erase_reg;
    end
  end

  // Hardware sets win over a clear arriving in the same cycle.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      fail_p_reg <= 1'b0;
      fail_e_reg <= 1'b0;
      prot_reg <= 1'b0;
    end else begin
      if ((timeout && !is_erase_reg) || (prot_err && op_prog)) begin
        fail_p_reg <= 1'b1;
      end else if (clr_fsr_in) begin
        fail_p_reg <= 1'b0;
      end
      if ((timeout && is_erase_reg) || (prot_err && op_erase)) begin
        fail_e_reg <= 1'b1;
      end else if (clr_fsr_in) begin
        fail_e_reg <= 1'b0;
      end
      if (prot_err) begin
        prot_reg <= 1'b1;
      end else if (clr_fsr_in) begin
        prot_reg <= 1'b0;
      end
    end
  end

  assign fsr_out = {ready_reg, susp_e_reg, fail_e_reg, fail_p_reg,
                    1'b0, susp_p_reg, prot_reg, 1'b0};

endmodule

// File: tb_serial_flash_program_erase_control.sv
`timescale 1ns/1ps
module tb_serial_flash_program_erase_control import flash_seq_pkg::*;;
  localparam int PS = 16;
  localparam int PW = 4;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic [1:0] proto_in = PROTO_EXT;
  logic clr_fsr_in = 1'b0;
  logic array_ready_in = 1'b1;
  logic addr4_in = 1'b0;
  logic suspend_in = 1'b0;
  logic resume_in = 1'b0;
  logic prot_hit_in, sel_n, sclk, mem_we, erase_start, erase_sector, wel;
  logic [3:0] lines;
  logic [31:0] prot_addr, mem_addr, erase_addr;
  logic [7:0] mem_data, fsr;
  int mismatches = 0;
  int samples_checked = 0;
  int cyc = 0;
  int erases = 0;
  logic [31:0] seed = 32'h83be;
  logic [31:0] wq_a[$];
  logic [7:0] wq_d[$];
  logic [31:0] e_ea = 32'h0;
  logic e_es = 1'b0;
  logic [7:0] codes[5] = '{8'h02, 8'ha2, 8'hd2, 8'h32, 8'h38};
  int wav[5] = '{1, 1, 2, 1, 4};
  int wdv[5] = '{1, 2, 2, 4, 4};
  logic [7:0] pcode[4] = '{8'ha2, 8'h32, 8'hd2, 8'h38};
  logic pok[4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  assign prot_hit_in = prot_addr[19:16] == 4'h7;
  serial_flash_program_erase_control #(.PAGE_SIZE(PS), .PP_CYCLES(40), .SSE_CYCLES(30),
    .SE_CYCLES(50)
  ) serial_flash_program_erase_control_i (.clk_in(clk_in), .srst_in(srst_in),
    .sel_n_in(sel_n), .sclk_in(sclk), .serial_line_in(lines), .proto_in(proto_in),
    .addr4_in(addr4_in), .clr_fsr_in(clr_fsr_in), .suspend_in(suspend_in),
    .resume_in(resume_in),
    .prot_addr_out(prot_addr), .prot_hit_in(prot_hit_in), .array_ready_in(array_ready_in),
    .mem_we_out(mem_we), .mem_addr_out(mem_addr), .mem_data_out(mem_data),
    .erase_start_out(erase_start), .erase_sector_out(erase_sector),
    .erase_addr_out(erase_addr), .wel_out(wel), .fsr_out(fsr));
  flash_host_model flash_host_model_i (.clk_in(clk_in), .sel_n_out(sel_n), .sclk_out(sclk),
    .line_out(lines));
  always #10 clk_in = ~clk_in;
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic int lw();
    return (proto_in == PROTO_QUAD) ? 4 : (proto_in == PROTO_DUAL) ? 2 : 1;
  endfunction
  task automatic print_verdict();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // Sends one frame; xb adds stray bits, run queues the writes a kept program makes.
  task automatic frame(input logic [7:0] cmd, input int wc, input int wa, input int wd,
                       input logic [31:0] a, input int nd, input int xb, input logic run);
    logic [7:0] pg[PS];
    bit vl[PS];
    int col;
    flash_host_model_i.start();
    flash_host_model_i.send(cmd, wc, 0);
    for (int i = addr4_in ? 3 : 2; i >= 0 && wa > 0; i--) begin
      flash_host_model_i.send(8'(a >> (8 * i)), wa, 0);
    end
    for (int n = 0; n < nd; n++) begin
      seed = lfsr(seed);
      col = (32'(a[PW-1:0]) + n) % PS;
      pg[col] = seed[7:0];
      vl[col] = 1'b1;
      flash_host_model_i.send(seed[7:0], wd, 0);
    end
    if (xb > 0) flash_host_model_i.send(8'h5a, 1, xb);
    flash_host_model_i.stop();
    for (int c = 0; c < PS && run; c++) begin
      if (vl[c]) begin
        wq_a.push_back({a[31:PW], PW'(c)});
        wq_d.push_back(pg[c]);
      end
    end
  endtask
  task automatic cmd(input logic [7:0] c, input int xb);
    frame(c, lw(), 0, 0, 32'h0, 0, xb, 1'b0);
  endtask
  // Polls status until ready, then compares status, latch and pending writes.
  task automatic settle(input logic busy, input logic [7:0] efsr, input logic ewel);
    int t;
    t = 0;
    while (busy && fsr[7] !== 1'b0 && t < 20) begin
      @(negedge clk_in);
      t++;
    end
    if (busy) chk("busy and latch", 32'h0, 32'({fsr[7], wel}));
    while (fsr[7] !== 1'b1 && t < 2000) begin
      @(negedge clk_in);
      t++;
    end
    repeat (20) @(negedge clk_in);
    chk("flag status", 32'(efsr), 32'(fsr));
    chk("latch", 32'(ewel), 32'(wel));
    chk("writes left", 32'h0, 32'(wq_a.size()));
  endtask
  task automatic clear();
    clr_fsr_in = 1'b1;
    @(negedge clk_in);
    clr_fsr_in = 1'b0;
    settle(1'b0, 8'h80, 1'b0);
  endtask
  ////////////////////////////////////////
  always @(negedge clk_in) begin
    if (mem_we === 1'b1) begin
      chk("write expected", 32'h1, 32'(wq_a.size() > 0));
      if (wq_a.size() > 0) begin
        chk("write address", wq_a.pop_front(), mem_addr);
        chk("write data", 32'(wq_d.pop_front()), 32'(mem_data));
      end
    end
    if (erase_start === 1'b1) begin
      erases++;
      chk("erase address", e_ea, erase_addr);
      chk("erase kind", 32'(e_es), 32'(erase_sector));
    end
  end
  always @(negedge clk_in) begin
    cyc++;
    if (cyc > 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  initial begin
    logic [31:0] a;
    repeat (10) @(negedge clk_in);
    srst_in = 1'b0;
    chk("reset status", 32'h80, 32'(fsr));
    chk("reset latch", 32'h0, 32'(wel));
    frame(8'h02, 1, 1, 1, 32'h100, 2, 0, 1'b0);
    settle(1'b0, 8'h80, 1'b0);
    cmd(8'h06, 3);
    settle(1'b0, 8'h80, 1'b0);
    cmd(8'h06, 0);
    settle(1'b0, 8'h80, 1'b1);
    cmd(8'h04, 2);
    settle(1'b0, 8'h80, 1'b1);
    frame(8'h02, 1, 1, 1, 32'h100, 2, 5, 1'b0);
    settle(1'b0, 8'h80, 1'b1);
    frame(8'h20, 1, 1, 0, 32'h3000, 0, 4, 1'b0);
    settle(1'b0, 8'h80, 1'b1);
    cmd(8'h04, 0);
    settle(1'b0, 8'h80, 1'b0);
    cmd(8'h06, 0);
    frame(8'h02, 1, 1, 1, 32'h01234e, 20, 0, 1'b1);
    settle(1'b1, 8'h80, 1'b0);
    addr4_in = 1'b1;
    cmd(8'h06, 0);
    frame(8'h02, 1, 1, 1, 32'h1a002345, 3, 0, 1'b1);
    settle(1'b1, 8'h80, 1'b0);
    addr4_in = 1'b0;
    for (int v = 0; v < 5; v++) begin
      cmd(8'h06, 0);
      frame(codes[v], 1, wav[v], wdv[v], 32'h2003 + 32'(v) * 32'h10, 2, 0, 1'b1);
      settle(1'b1, 8'h80, 1'b0);
    end
    for (int p = 0; p < 4; p++) begin
      proto_in = (p < 2) ? PROTO_DUAL : PROTO_QUAD;
      cmd(8'h06, 0);
      frame(pcode[p], lw(), lw(), lw(), 32'h4005, 1, 0, pok[p]);
      settle(pok[p], 8'h80, !pok[p]);
    end
    proto_in = PROTO_EXT;
    cmd(8'h06, 0);
    frame(8'h02, 1, 1, 1, 32'h75000, 1, 0, 1'b0);
    settle(1'b0, 8'h92, 1'b1);
    cmd(8'h04, 0);
    settle(1'b0, 8'h92, 1'b1);
    clear();
    cmd(8'h06, 0);
    frame(8'hd8, 1, 1, 0, 32'h70000, 0, 0, 1'b0);
    settle(1'b0, 8'ha2, 1'b1);
    clear();
    array_ready_in = 1'b0;
    cmd(8'h06, 0);
    frame(8'h02, 1, 1, 1, 32'h8009, 1, 0, 1'b1);
    settle(1'b1, 8'h90, 1'b0);
    clear();
    e_ea = 32'h9000;
    cmd(8'h06, 0);
    frame(8'h20, 1, 1, 0, 32'h9abc, 0, 0, 1'b0);
    settle(1'b1, 8'ha0, 1'b0);
    clear();
    array_ready_in = 1'b1;
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      a = {12'h0, 4'h3, seed[15:0]};
      e_es = (k == 1);
      e_ea = (k == 1) ? {a[31:16], 16'h0} : {a[31:12], 12'h0};
      cmd(8'h06, 0);
      frame((k == 1) ? 8'hd8 : 8'h20, 1, 1, 0, a, 0, 0, 1'b0);
      settle(1'b1, 8'h80, 1'b0);
    end
    e_es = 1'b0;
    e_ea = 32'h3000;
    cmd(8'h06, 0);
    frame(8'h20, 1, 1, 0, 32'h3abc, 0, 0, 1'b0);
    repeat (8) @(negedge clk_in);
    suspend_in = 1'b1;
    @(negedge clk_in);
    suspend_in = 1'b0;
    repeat (40) @(negedge clk_in);
    chk("suspended status", 32'hc0, 32'(fsr));
    resume_in = 1'b1;
    @(negedge clk_in);
    resume_in = 1'b0;
    settle(1'b1, 8'h80, 1'b0);
    frame(8'hd8, 1, 1, 0, 32'h30000, 0, 0, 1'b0);
    settle(1'b0, 8'h80, 1'b0);
    chk("erase starts", 32'h4, 32'(erases));
    print_verdict();
  end
endmodule
